// file: aac_pkg.sv
// constants, register map and state type of the converter control block
// assumes one master clock domain; pins are synchronised in the top module
// Notes on behaviour
// R1: master clock is 384 or 256 fs by pin
// R2: divide to 64 fs modulator clock, fs words
// R3: master mode makes serial clocks from master clock
// R4: slave mode clocks come from common source
// R5: reset initialises filter and clears output buffer
// R6: outputs low in reset, bit clock at select
// R7: reset async; shared release on falling edge (code releases on a rising clock edge after two synchroniser flops)
// R8: shared clock and reset start sampling together
// R9: slave waits for frame fall then rise
// R10: word clock input needs high, low, high
// R11: 8192 frame offset calibration after reset
// R12: slave calibration count starts after frame rise
// R13: reset low powers down, recalibrates on release
// R14: two-bit level tag, msb first, frame synchronous
// R15: level tag recomputed every sample, not peak
// R16: tag codes 00,01,10,11 around full scale
// R17: twos complement words, msb first, left then right
// R18: divider held in known phase during reset
package aac_pkg;

   // ----------------------------------------
   // clock ratios and frame layout
   // ----------------------------------------
   localparam int MOD_RATIO = 64;
   localparam int RATIO_LO = 256;
   localparam int RATIO_HI = 384;
   localparam int DIV_LO = RATIO_LO / MOD_RATIO;
   localparam int DIV_HI = RATIO_HI / MOD_RATIO;
   localparam int DIV_W = 3;
   localparam int FRAME_BITS = 64;
   localparam int SAMPLE_W = 16;
   localparam int RIGHT_START = 32;
   localparam int CAL_FRAMES = 8192;
   localparam int FRAME_CNT_W = 16;

   // ----------------------------------------
   // level thresholds on 17-bit magnitude, full scale = 2^16
   // ----------------------------------------
   localparam logic [16:0] LVL_M1DB = 17'h0E429;
   localparam logic [16:0] LVL_FS = 17'h10000;
   localparam logic [16:0] LVL_P1DB = 17'h11F3C;

   // ----------------------------------------
   // register map, byte addresses
   // ----------------------------------------
   localparam int ADR_W = 8;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
   localparam logic [7:0] OFF_FRAMES = 8'h10;
   localparam int CTRL_SOFT_RESET = 0;
   localparam int IRQ_CAL_DONE = 0;
   localparam int IRQ_OVERRANGE = 1;
   localparam int IRQ_SYNCED = 2;
   localparam int IRQ_W = 3;
   localparam logic CTRL_RESET_VAL = 1'b0;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RESET_VAL = 3'h0;

   typedef enum logic [2:0] {
      ST_OFF, ST_ARM_HIGH, ST_WAIT_LOW, ST_WAIT_RISE, ST_CAL, ST_RUN
   } aac_state_t;

endpackage

// file: aac_top.sv
// converter control: clock divider, reset and power down, start-up
// gating, offset calibration timing, serial words and level tag
// assumes decimator samples arrive on the master clock domain
`timescale 1ns/1ps
`default_nettype none
module aac_top #(
   parameter int CAL_LEN = aac_pkg::CAL_FRAMES
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [aac_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq,
   input wire logic reset_n_pin,
   input wire logic ratio_384_sel,
   input wire logic slave_mode,
   input wire logic bit_clock_edge_select,
   input wire logic word_clock_input_mode,
   input wire logic channel_frame_clock_in,
   input wire logic word_clock_in,
   input wire logic [15:0] dec_left,
   input wire logic [15:0] dec_right,
   input wire logic [16:0] dec_peak,
   output logic modulator_clock,
   output logic filter_init,
   output logic powered_down,
   output logic calibrating,
   output logic bit_clock_out,
   output logic channel_frame_clock_out,
   output logic word_clock_out,
   output logic serial_clocks_oe_n,
   output logic serial_data_out,
   output logic level_tag_out
);
   import aac_pkg::*;

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   localparam int SYNC_W = 7;
   logic [SYNC_W-1:0] pin_raw;
   logic [SYNC_W-1:0] meta_ff;
   logic [SYNC_W-1:0] sync_ff;
   assign pin_raw = {word_clock_in, channel_frame_clock_in, word_clock_input_mode,
      bit_clock_edge_select, slave_mode, ratio_384_sel, reset_n_pin};

   // reset pin is asynchronous, so it is caught here like any other pin
   always_ff @(posedge clock) begin // R7
      if (rst) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= pin_raw;
         sync_ff <= meta_ff;
      end
   end

   wire s_reset_n = sync_ff[0];
   wire s_ratio = sync_ff[1];
   wire s_slave = sync_ff[2];
   wire s_edge = sync_ff[3];
   wire s_wclk_mode = sync_ff[4];
   wire s_channel_frame_clock = sync_ff[5];
   wire s_wclk = sync_ff[6];

   // ----------------------------------------
   // registers and state
   // ----------------------------------------
   aac_state_t state_ff, nxt_state;
   logic ctrl_soft_ff;
   logic [IRQ_W-1:0] irq_stat_ff, nxt_irq_stat, irq_mask_ff;
   logic ack_ff;
   logic [31:0] dat_o_ff;
   logic [DIV_W-1:0] div_cnt_ff, nxt_div_cnt;
   logic [5:0] bit_cnt_ff, nxt_bit_cnt;
   logic [13:0] cal_cnt_ff;
   logic [FRAME_CNT_W-1:0] frames_ff;
   logic channel_frame_clock_d_ff;
   logic [SAMPLE_W-1:0] left_buf_ff, right_buf_ff;
   logic [1:0] tag_buf_ff;
   logic mod_clk_ff, bclk_ff, channel_frame_clock_out_ff, wclk_out_ff, sdo_ff, tag_out_ff;

   // device held while the pin is low or software asks for it
   wire dev_reset = rst | ~s_reset_n | ctrl_soft_ff; // R13
   // state decodes shared by outputs, buffers and status
   wire st_cal = (state_ff == ST_CAL);
   wire st_run = (state_ff == ST_RUN);

   // ----------------------------------------
   // helper functions
   // ----------------------------------------
   function automatic logic [1:0] level_code(input logic [16:0] mag);
      if (mag > LVL_P1DB) begin
         level_code = 2'h3;
      end else if (mag >= LVL_FS) begin
         level_code = 2'h2;
      end else if (mag >= LVL_M1DB) begin
         level_code = 2'h1;
      end else begin
         level_code = 2'h0;
      end
   endfunction

   function automatic logic in_word(input logic [5:0] b);
      in_word = (b < 6'(SAMPLE_W)) ||
         (b >= 6'(RIGHT_START) && b < 6'(RIGHT_START + SAMPLE_W));
   endfunction

   // ----------------------------------------
   // divider and frame position
   // ----------------------------------------
   wire [DIV_W-1:0] div_len = s_ratio ? DIV_W'(DIV_HI) : DIV_W'(DIV_LO); // R1
   wire div_wrap = (div_cnt_ff == div_len - 3'h1);
   wire channel_frame_clock_rise = s_channel_frame_clock & ~channel_frame_clock_d_ff;
   wire channel_frame_clock_fall = ~s_channel_frame_clock & channel_frame_clock_d_ff;
   wire active = st_cal | st_run;
   wire frame_end = div_wrap && (bit_cnt_ff == 6'(FRAME_BITS - 1));
   // slave frames restart on the partner's frame edge; common source assumed
   wire realign = s_slave & channel_frame_clock_rise; // R4
   wire frame_tick = active & (s_slave ? channel_frame_clock_rise : frame_end); // R2

   always_comb begin
      nxt_div_cnt = div_wrap ? '0 : div_cnt_ff + 3'h1; // R2
      nxt_bit_cnt = div_wrap ? bit_cnt_ff + 6'h1 : bit_cnt_ff;
      if (!active || realign) begin
         nxt_div_cnt = '0;
         nxt_bit_cnt = '0;
      end
   end

   // a fixed start phase keeps parts released together in step
   always_ff @(posedge clock) begin // R18 R8
      if (dev_reset) begin
         div_cnt_ff <= '0;
         bit_cnt_ff <= '0;
         channel_frame_clock_d_ff <= 1'b0;
      end else begin
         div_cnt_ff <= nxt_div_cnt;
         bit_cnt_ff <= nxt_bit_cnt;
         channel_frame_clock_d_ff <= s_channel_frame_clock;
      end
   end

   // ----------------------------------------
   // start-up sequence
   // ----------------------------------------
   // fourteen bits limit the calibration length to 16384 frames
   wire cal_last = (cal_cnt_ff == 14'(CAL_LEN - 1));
   wire cal_step = st_cal & frame_tick;
   wire cal_done = cal_step & cal_last;
   wire need_wclk = s_slave & s_wclk_mode;
   wire step_ok = ~need_wclk | s_wclk;

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_OFF: begin
            if (!s_slave) begin
               nxt_state = ST_CAL; // R3
            end else if (need_wclk) begin
               nxt_state = ST_ARM_HIGH;
            end else begin
               nxt_state = ST_WAIT_LOW;
            end
         end
         ST_ARM_HIGH: begin
            if (s_wclk && s_channel_frame_clock) begin
               nxt_state = ST_WAIT_LOW; // R10
            end
         end
         ST_WAIT_LOW: begin
            if ((channel_frame_clock_fall || (need_wclk && !s_channel_frame_clock)) && step_ok) begin
               nxt_state = ST_WAIT_RISE; // R9
            end
         end
         ST_WAIT_RISE: begin
            if (channel_frame_clock_rise && step_ok) begin
               nxt_state = ST_CAL; // R12
            end
         end
         ST_CAL: begin
            if (cal_done) begin
               nxt_state = ST_RUN; // R11
            end
         end
         ST_RUN: begin
            nxt_state = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (dev_reset) begin
         state_ff <= ST_OFF; // R13 R8
         cal_cnt_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         if (cal_step) begin
            cal_cnt_ff <= cal_cnt_ff + 14'h1; // R11
         end
      end
   end

   // ----------------------------------------
   // sample buffers
   // ----------------------------------------
   wire take_sample = frame_tick & st_run;
   // one decode feeds both the buffer and the overrange event
   wire [1:0] live_code = level_code(dec_peak); // R16

   // buffer cleared in reset and kept zero until calibration ends
   always_ff @(posedge clock) begin // R5
      if (dev_reset) begin
         left_buf_ff <= '0;
         right_buf_ff <= '0;
         tag_buf_ff <= '0;
         frames_ff <= '0;
      end else if (take_sample) begin
         left_buf_ff <= dec_left;
         right_buf_ff <= dec_right;
         tag_buf_ff <= live_code; // R15 R16
         frames_ff <= frames_ff + 16'h1;
      end
   end

   // ----------------------------------------
   // serial outputs
   // ----------------------------------------
   wire [5:0] b = bit_cnt_ff;
   wire [3:0] li = 4'(6'(SAMPLE_W - 1) - b);
   wire [3:0] ri = 4'(6'(RIGHT_START + SAMPLE_W - 1) - b);
   wire data_bit = (b < 6'(RIGHT_START)) ? left_buf_ff[li] : right_buf_ff[ri];
   wire half_hi = (div_cnt_ff < (div_len >> 1));
   wire tag_bit = (b == 6'h0) ? tag_buf_ff[1] : tag_buf_ff[0];
   wire nxt_mod_clk = active & half_hi; // R2
   wire nxt_bclk = (active & ~s_slave) ? (half_hi ^ s_edge) : s_edge; // R3
   wire nxt_channel_frame_clock_out = active & ~s_slave & (b < 6'(RIGHT_START));
   wire nxt_wclk_out = active & ~need_wclk & in_word(b);
   wire nxt_sdo = active & in_word(b) & data_bit; // R17
   wire nxt_tag_out = active & (b < 6'h2) & tag_bit; // R14

   always_ff @(posedge clock) begin // R6
      if (dev_reset) begin
         mod_clk_ff <= 1'b0;
         bclk_ff <= s_edge;
         channel_frame_clock_out_ff <= 1'b0;
         wclk_out_ff <= 1'b0;
         sdo_ff <= 1'b0;
         tag_out_ff <= 1'b0;
      end else begin
         mod_clk_ff <= nxt_mod_clk;
         bclk_ff <= nxt_bclk;
         channel_frame_clock_out_ff <= nxt_channel_frame_clock_out;
         wclk_out_ff <= nxt_wclk_out;
         sdo_ff <= nxt_sdo;
         tag_out_ff <= nxt_tag_out;
      end
   end

   assign modulator_clock = mod_clk_ff;
   assign bit_clock_out = bclk_ff;
   assign channel_frame_clock_out = channel_frame_clock_out_ff;
   assign word_clock_out = wclk_out_ff;
   assign serial_data_out = sdo_ff;
   assign level_tag_out = tag_out_ff;
   assign serial_clocks_oe_n = s_slave;
   assign filter_init = dev_reset; // R5
   assign powered_down = ~active; // R13
   assign calibrating = st_cal;

   // ----------------------------------------
   // wishbone slave
   // ----------------------------------------
   wire wb_req = wb_cyc_i & wb_stb_i;
   wire [5:0] wa = wb_adr_i[7:2];
   wire hit_ctrl = (wa == OFF_CTRL[7:2]);
   wire hit_status = (wa == OFF_STATUS[7:2]);
   wire hit_stat = (wa == OFF_IRQ_STAT[7:2]);
   wire hit_mask = (wa == OFF_IRQ_MASK[7:2]);
   wire hit_frames = (wa == OFF_FRAMES[7:2]);
   // a read is latched once, on the edge that takes the request
   wire rd_take = wb_req & ~ack_ff;
   // writes land on the acknowledged edge only
   wire wr_take = wb_req & wb_we_i & ack_ff & wb_sel_i[0];
   wire [31:0] status_word = {22'h0, tag_buf_ff, 1'b0, s_wclk_mode, s_ratio,
      s_slave, st_run, st_cal, ~active, s_reset_n};
   wire [31:0] rd_mux = hit_ctrl ? {31'h0, ctrl_soft_ff} :
      hit_status ? status_word :
      hit_stat ? {29'h0, irq_stat_ff} :
      hit_mask ? {29'h0, irq_mask_ff} :
      hit_frames ? {16'h0, frames_ff} : 32'h0;

   // ----------------------------------------
   // interrupt status
   // ----------------------------------------
   logic [IRQ_W-1:0] evt;
   logic [IRQ_W-1:0] clr;
   always_comb begin
      evt = '0;
      evt[IRQ_CAL_DONE] = cal_done;
      evt[IRQ_OVERRANGE] = take_sample && live_code == 2'h3;
      evt[IRQ_SYNCED] = state_ff == ST_WAIT_RISE && nxt_state == ST_CAL;
      clr = (wr_take && hit_stat) ? wb_dat_i[IRQ_W-1:0] : '0;
      // a new event beats a clear in the same cycle
      nxt_irq_stat = (irq_stat_ff & ~clr) | evt;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         ack_ff <= 1'b0;
         dat_o_ff <= '0;
         ctrl_soft_ff <= CTRL_RESET_VAL;
         irq_mask_ff <= IRQ_MASK_RESET_VAL;
         irq_stat_ff <= '0;
      end else begin
         ack_ff <= rd_take;
         if (rd_take) begin
            dat_o_ff <= rd_mux;
         end
         if (wr_take && hit_ctrl) begin
            ctrl_soft_ff <= wb_dat_i[CTRL_SOFT_RESET];
         end
         if (wr_take && hit_mask) begin
            irq_mask_ff <= wb_dat_i[IRQ_W-1:0];
         end
         irq_stat_ff <= nxt_irq_stat;
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = dat_o_ff;
   wire [IRQ_W-1:0] irq_live = irq_stat_ff & irq_mask_ff;
   assign irq = |irq_live;

endmodule
`default_nettype wire

// file: aac_top_sva.sv
// assertion checker for the converter control block, bound to aac_top
// assumes ratio and mode pins change only while reset is applied
`timescale 1ns/1ps
`default_nettype none
module aac_top_sva #(
   parameter int CAL_LEN = aac_pkg::CAL_FRAMES
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic ratio_384_sel,
   input wire logic slave_mode,
   input wire logic modulator_clock,
   input wire logic filter_init,
   input wire logic powered_down,
   input wire logic calibrating,
   input wire logic channel_frame_clock_out,
   input wire logic word_clock_out,
   input wire logic serial_clocks_oe_n,
   input wire logic serial_data_out,
   input wire logic level_tag_out
);
   // ----------------------------------------
   // frame position and calibration counters
   // ----------------------------------------
   logic [15:0] cnt_ff;
   logic [15:0] cal_ff;
   logic seen_ff;
   logic lr_q_ff;
   wire lr_rise = channel_frame_clock_out && !lr_q_ff;
   wire [15:0] per = ratio_384_sel ? 16'h0180 : 16'h0100;
   always_ff @(posedge clock) begin
      lr_q_ff <= channel_frame_clock_out;
      cnt_ff <= lr_rise ? 16'h0001 : cnt_ff + 16'h0001;
      seen_ff <= (rst || filter_init) ? 1'h0 : (seen_ff || lr_rise);
      cal_ff <= calibrating ? cal_ff + 16'h0001 : 16'h0000;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst || filter_init);
   // first period only is unchecked: seen_ff guards the counter
   property p_div_lo;
      $rose(modulator_clock) && !ratio_384_sel |->
         modulator_clock[*2] ##1 !modulator_clock[*2] ##1 modulator_clock;
   endproperty
   a_div_lo: assert property (p_div_lo) else $error("divide by 4 broken");
   property p_div_hi;
      $rose(modulator_clock) && ratio_384_sel |->
         modulator_clock[*3] ##1 !modulator_clock[*3] ##1 modulator_clock;
   endproperty
   a_div_hi: assert property (p_div_hi) else $error("divide by 6 broken");
   property p_frame;
      lr_rise && seen_ff && !slave_mode |-> cnt_ff == per;
   endproperty
   a_frame: assert property (p_frame) else $error("frame length wrong");
   property p_left_half;
      !channel_frame_clock_out && lr_q_ff && seen_ff && !slave_mode |-> cnt_ff == per / 2;
   endproperty
   a_left_half: assert property (p_left_half) else $error("left half wrong");
   property p_tag_window;
      level_tag_out && !slave_mode |-> channel_frame_clock_out && (lr_rise || cnt_ff <= 16'h000D);
   endproperty
   a_tag_window: assert property (p_tag_window) else $error("tag outside slot");
   property p_quiet;
      powered_down && $past(powered_down) |->
         $stable(serial_data_out) && $stable(level_tag_out) && $stable(word_clock_out);
   endproperty
   a_quiet: assert property (p_quiet) else $error("output moved while idle");
   property p_reset_out;
      @(posedge clock) disable iff (rst) filter_init && $past(filter_init) |-> !serial_data_out
         && !level_tag_out && !word_clock_out && !channel_frame_clock_out;
   endproperty
   a_reset_out: assert property (p_reset_out) else $error("output high in reset");
   property p_cal_len;
      $fell(calibrating) && !slave_mode |->
         cal_ff + 2 >= CAL_LEN * per && cal_ff <= CAL_LEN * per + 2;
   endproperty
   a_cal_len: assert property (p_cal_len) else $error("calibration length wrong");
   property p_oe;
      $stable(slave_mode)[*3] |-> serial_clocks_oe_n == slave_mode;
   endproperty
   a_oe: assert property (p_oe) else $error("clock drive mode wrong");
   property p_ack;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("bus answer wrong");
endmodule
bind aac_top aac_top_sva #(.CAL_LEN(CAL_LEN)) aac_top_sva_inst (.clock, .rst, .wb_cyc_i,
   .wb_stb_i, .wb_ack_o, .ratio_384_sel, .slave_mode, .modulator_clock, .filter_init,
   .powered_down, .calibrating, .channel_frame_clock_out, .word_clock_out,
   .serial_clocks_oe_n, .serial_data_out, .level_tag_out);
`default_nettype wire

// file: aac_partner.sv
// serial receiver model: frame clock source in slave mode, frame capture
// assumes it runs on the same master clock as the device
`timescale 1ns/1ps
`default_nettype none
module aac_partner (
   input wire logic clock,
   input wire logic ratio_384_sel,
   input wire logic run,
   input wire logic level,
   input wire logic frame_in,
   input wire logic data_in,
   input wire logic tag_in,
   output logic frame_out,
   output logic [63:0] data_word,
   output logic [63:0] tag_word
);
   // ----------------------------------------
   // capture at mid bit, publish at frame rise
   // ----------------------------------------
   logic [63:0] dsh_ff;
   logic [63:0] tsh_ff;
   logic [9:0] pos_ff;
   logic [9:0] gen_ff;
   logic fq_ff;
   wire [9:0] div = ratio_384_sel ? 10'h006 : 10'h004;
   wire [9:0] half = div * 10'h020;
   always @(posedge clock) begin
      fq_ff <= frame_in;
      pos_ff <= (frame_in && !fq_ff) ? 10'h001 : pos_ff + 10'h001;
      if (pos_ff % div == div / 2) begin
         dsh_ff <= {dsh_ff[62:0], data_in};
         tsh_ff <= {tsh_ff[62:0], tag_in};
      end
      if (frame_in && !fq_ff) begin
         data_word <= dsh_ff;
         tag_word <= tsh_ff;
      end
      // frames stand still at the given level unless running
      gen_ff <= (!run || gen_ff == half - 10'h001) ? 10'h000 : gen_ff + 10'h001;
      frame_out <= !run ? level : (gen_ff == half - 10'h001) ^ frame_out;
   end
endmodule
`default_nettype wire

// file: aac_top_test.sv
// self-checking bench for aac_top with a receiver model on the serial side
// assumes a short calibration parameter so the run stays brief
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin errors++; \
   $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end
module aac_top_test;
   import aac_pkg::*;
   // ----------------------------------------
   // stimulus, tasks and scenarios
   // ----------------------------------------
   logic clock = 1'h0, rst = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic wb_ack_o, irq, reset_n_pin = 1'h1, ratio_384_sel = 1'h0, slave_mode = 1'h0;
   logic bit_clock_edge_select = 1'h0, word_clock_input_mode = 1'h0, word_clock_in = 1'h1;
   logic [15:0] dec_left = 16'h0, dec_right = 16'h0, el, er;
   logic [16:0] dec_peak = 17'h0, ep;
   logic modulator_clock, filter_init, powered_down, calibrating, bit_clock_out;
   logic channel_frame_clock_in, channel_frame_clock_out, word_clock_out, serial_clocks_oe_n;
   logic serial_data_out, level_tag_out, run = 1'h0, level = 1'h1;
   logic [63:0] data_word, tag_word;
   logic [16:0] band [4] = '{17'h14000, 17'h08000, 17'h11000, 17'h0F000};
   int errors = 0, check_count = 0, cycles = 0, seed = 39;
   aac_top #(.CAL_LEN(4)) aac_top_inst (.clock, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq, .reset_n_pin,
      .ratio_384_sel, .slave_mode, .bit_clock_edge_select, .word_clock_input_mode,
      .channel_frame_clock_in, .word_clock_in, .dec_left, .dec_right, .dec_peak,
      .modulator_clock, .filter_init, .powered_down, .calibrating, .bit_clock_out,
      .channel_frame_clock_out, .word_clock_out, .serial_clocks_oe_n, .serial_data_out,
      .level_tag_out);
   aac_partner aac_partner_inst (.clock, .ratio_384_sel, .run, .level,
      .frame_in(channel_frame_clock_out), .data_in(serial_data_out), .tag_in(level_tag_out),
      .frame_out(channel_frame_clock_in), .data_word, .tag_word);
   always #50 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (cycles == 30000) begin
         errors++;
         conclude();
      end
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      @(posedge clock);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      do @(posedge clock); while (wb_ack_o !== 1'h1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      wb_we_i <= 1'h0;
   endtask
   task automatic wait_sig(ref logic sig, input logic val, input int lim);
      int n;
      n = 0;
      while (sig !== val && n < lim) begin
         @(posedge clock);
         n++;
      end
   endtask
   task automatic restart(input logic ratio, input logic slave);
      rst <= 1'h1;
      ratio_384_sel <= ratio;
      slave_mode <= slave;
      repeat (4) @(posedge clock);
      rst <= 1'h0;
      @(posedge clock);
   endtask
   function automatic logic [1:0] tag_of(input logic [16:0] p);
      return (p > LVL_P1DB) ? 2'h3 : (p >= LVL_FS) ? 2'h2 : (p >= LVL_M1DB) ? 2'h1 : 2'h0;
   endfunction
   initial begin
      for (int r = 0; r < 2; r++) begin
         restart(r[0], 1'h0);
         wait_sig(calibrating, 1'h1, 20);
         `CHK("calibrating", 1'h1, calibrating)
         `CHK("clock drive", 1'h0, serial_clocks_oe_n)
         wait_sig(calibrating, 1'h0, 3000);
         wait_sig(channel_frame_clock_out, 1'h1, 800);
         for (int i = 0; i < 6; i++) begin
            el = 16'($random(seed));
            er = 16'($random(seed));
            ep = band[i % 4] + 17'($random(seed) & 32'h3FF);
            dec_left <= el;
            dec_right <= er;
            dec_peak <= ep;
            repeat (2) begin
               wait_sig(channel_frame_clock_out, 1'h0, 800);
               wait_sig(channel_frame_clock_out, 1'h1, 800);
            end
            @(posedge clock);
            `CHK("left word", el, data_word[63:48])
            `CHK("right word", er, data_word[31:16])
            `CHK("level tag", tag_of(ep), tag_word[63:62])
         end
         $display("master run %0d done", r);
      end
      wb(1'h0, OFF_CTRL, 32'h0);
      `CHK("ctrl reset", 32'h0, rd)
      wb(1'h0, OFF_IRQ_MASK, 32'h0);
      `CHK("mask reset", 32'h0, rd)
      wb(1'h0, 8'h20, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      wb(1'h0, OFF_IRQ_STAT, 32'h0);
      `CHK("irq status", 32'h3, rd)
      `CHK("irq masked", 1'h0, irq)
      wb(1'h1, OFF_IRQ_MASK, 32'h1);
      repeat (2) @(posedge clock);
      `CHK("irq raised", 1'h1, irq)
      wb(1'h1, OFF_IRQ_STAT, 32'h1);
      repeat (2) @(posedge clock);
      `CHK("irq cleared", 1'h0, irq)
      wb(1'h1, OFF_CTRL, 32'h1);
      @(posedge clock);
      `CHK("soft reset", 1'h1, filter_init)
      wb(1'h1, OFF_CTRL, 32'h0);
      $display("register test done");
      bit_clock_edge_select <= 1'h1;
      reset_n_pin <= 1'h0;
      repeat (5) @(posedge clock);
      `CHK("pin power down", 1'h1, powered_down)
      `CHK("bit clock level", 1'h1, bit_clock_out)
      `CHK("data low", 1'h0, serial_data_out)
      reset_n_pin <= 1'h1;
      wait_sig(calibrating, 1'h1, 10);
      `CHK("recalibrate", 1'h1, calibrating)
      $display("pin reset test done");
      restart(1'h0, 1'h1);
      repeat (40) @(posedge clock);
      `CHK("slave wait high", 1'h0, calibrating)
      level <= 1'h0;
      repeat (40) @(posedge clock);
      `CHK("slave wait low", 1'h0, calibrating)
      level <= 1'h1;
      wait_sig(calibrating, 1'h1, 12);
      `CHK("slave start", 1'h1, calibrating)
      `CHK("slave clocks in", 1'h1, serial_clocks_oe_n)
      run <= 1'h1;
      wait_sig(calibrating, 1'h0, 2000);
      `CHK("slave cal end", 1'h0, calibrating)
      $display("slave test done");
      word_clock_input_mode <= 1'h1;
      word_clock_in <= 1'h0;
      run <= 1'h0;
      restart(1'h0, 1'h1);
      repeat (10) @(posedge clock);
      level <= 1'h0;
      repeat (10) @(posedge clock);
      level <= 1'h1;
      repeat (10) @(posedge clock);
      `CHK("wclk low refused", 1'h0, calibrating)
      word_clock_in <= 1'h1;
      repeat (10) @(posedge clock);
      level <= 1'h0;
      repeat (10) @(posedge clock);
      `CHK("wclk wait rise", 1'h0, calibrating)
      level <= 1'h1;
      wait_sig(calibrating, 1'h1, 12);
      `CHK("wclk start", 1'h1, calibrating)
      $display("word clock test done");
      conclude();
   end
endmodule
`default_nettype wire
